// File: pkg/ctsv_pkg.sv
// constants, register map and types of the current transformer supervision block
// assumes a 40 MHz MCLK and measurements scaled in units of 0.01 x In
package ctsv_pkg;
  // widths
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int CW = 16;
  localparam int TW = 48;
  localparam int RW = 19;
  localparam int FW = 5;
  localparam int GW = 3;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_RATIO = 8'h08;
  localparam logic [7:0] ADDR_SUMDIFF = 8'h0c;
  localparam logic [7:0] ADDR_DELAY = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_REMAIN = 8'h18;
  localparam logic [7:0] ADDR_COUNT = 8'h1c;
  localparam logic [7:0] ADDR_LOGSEL = 8'h20;
  localparam logic [7:0] ADDR_LOGDATA = 8'h24;
  // control field positions
  localparam int CTRL_RES_BIT = 0;
  localparam int CTRL_AFLT_LSB = 1;
  localparam int CTRL_BFLT_LSB = 3;
  localparam int CTRL_CLR_BIT = 8;
  // filter bits inside each two-bit filter field
  localparam int FLT_ON_BIT = 0;
  localparam int FLT_OFF_BIT = 1;
  // log select field positions
  localparam int LSEL_ENTRY_LSB = 0;
  localparam int LSEL_WORD_LSB = 8;
  localparam int LSEL_COUNT_LSB = 16;
  // status field positions
  localparam int STAT_START_BIT = 0;
  localparam int STAT_ALARM_BIT = 1;
  localparam int STAT_BLOCK_BIT = 2;
  localparam int STAT_FAULT_LSB = 3;
  // fault code bit positions
  localparam int FC_HIGH = 0;
  localparam int FC_ALLLOW = 1;
  localparam int FC_RATIO = 2;
  localparam int FC_SEQ = 3;
  localparam int FC_DIFF = 4;
  // reset values of the settings
  localparam logic [CW-1:0] RST_HIGH = 16'h0078;
  localparam logic [CW-1:0] RST_LOW = 16'h000a;
  localparam logic [CW-1:0] RST_RATIO = 16'h03e8;
  localparam logic [CW-1:0] RST_SEQ = 16'h1324;
  localparam logic [CW-1:0] RST_SUMDIFF = 16'h000a;
  localparam logic [RW-1:0] RST_DELAY = 19'h00064;
  localparam logic [1:0] RST_FILTER = 2'h3;
  localparam logic [RW-1:0] MAX_DELAY = 19'h57e40;
  // 100.00 percent in 0.01 percent units
  localparam logic [DW-1:0] RATIO_SCALE = 32'h00002710;
  // delay step timing
  localparam int STEP_MS = 5;
  localparam int CLK_KHZ = 40000;
  localparam int STEP_CYCLES = STEP_MS * CLK_KHZ;
  localparam int TICK_W = 18;
  // record log
  localparam int LOG_DEPTH = 12;
  localparam int LOG_AW = 4;
  localparam int LOG_WORDS = 7;
  localparam int LOG_WIDTH = LOG_WORDS * DW;
  localparam int CNT_W = 16;
  typedef enum logic [1:0] {EV_ALARM_ON, EV_ALARM_OFF, EV_BLOCK_ON, EV_BLOCK_OFF} ctsv_event_e;
  typedef enum logic [1:0] {ST_IDLE, ST_TIMING, ST_ALARM, ST_BLOCKED} ctsv_state_e;
endpackage

// File: design/ctsv_log_mem.sv
// record store of the supervision log, one write port and one read port
// assumes the owner keeps addresses below the depth; read data are registered
`timescale 1ns/1ps
module ctsv_log_mem #(
  parameter int WIDTH = ctsv_pkg::LOG_WIDTH,
  parameter int DEPTH = ctsv_pkg::LOG_DEPTH,
  parameter int ABITS = ctsv_pkg::LOG_AW
) (
  // clock
  input wire logic clk,
  // write side
  input wire logic wr_en,
  input wire logic [ABITS-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic [ABITS-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // contents are not reset; the owner masks entries not yet written
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read every cycle so a new selection shows one cycle later
  always_ff @(posedge clk)
  begin
    rd_data <= mem[rd_addr];
  end
endmodule

// File: design/ctsv_top.sv
// current transformer supervision: condition check, alarm delay, events,
// cumulative counter and a rolling log of time-stamped records
// assumes measurements, block input and time come from logic on MCLK and
// stay steady while PROG_CYCLE is high
//
// Functional notes
// [RQ1] alarm only after conditions persist full delay
// [RQ2] any phase above upper limit blocks activation
// [RQ3] all phases below lower limit block activation
// [RQ4] residual selected: difference must reach mismatch threshold
// [RQ5] zero residual difference withholds activation
// [RQ6] high-impedance earth fault below threshold stays inactive
// [RQ7] without residual check, unbalance alone alarms
// [RQ8] alarm and block on/off events from status
// [RQ9] per-type filter stores on, off or both
// [RQ10] every event carries a time stamp
// [RQ11] clearable cumulative alarm and block counter
// [RQ12] supervision outputs driven as plain pins
// [RQ13] rolling log of last twelve records
// [RQ14] record holds time, event, fault code, group
// [RQ15] record holds seven currents at trigger
// [RQ16] record holds remaining alarm time
// [RQ17] min/max ratio below, sequence ratio above threshold
// [RQ18] block sampled per cycle, replaces and resets start
// [RQ19] delay zero to 1800 s in 5 ms steps
// [RQ20] conditions lost: timer cleared, alarm dropped
`timescale 1ns/1ps
module ctsv_top #(
  parameter int STEP_CYCLES = ctsv_pkg::STEP_CYCLES
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // register port
  input wire logic [ctsv_pkg::AW-1:0] ADDR,
  input wire logic [ctsv_pkg::DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [ctsv_pkg::DW-1:0] RDATA,
  // program cycle context
  input wire logic PROG_CYCLE,
  input wire logic BLOCK_IN,
  input wire logic [ctsv_pkg::TW-1:0] TIME_MS,
  input wire logic [ctsv_pkg::GW-1:0] SET_GROUP,
  // measurements
  input wire logic [ctsv_pkg::CW-1:0] I_L1,
  input wire logic [ctsv_pkg::CW-1:0] I_L2,
  input wire logic [ctsv_pkg::CW-1:0] I_L3,
  input wire logic [ctsv_pkg::CW-1:0] I_RES1,
  input wire logic [ctsv_pkg::CW-1:0] I_RES2,
  input wire logic [ctsv_pkg::CW-1:0] I_POS,
  input wire logic [ctsv_pkg::CW-1:0] I_NEG,
  input wire logic [ctsv_pkg::CW-1:0] I_SUM_DIFF,
  // supervision outputs
  output logic START,
  output logic ALARM,
  output logic BLOCKED,
  output logic [ctsv_pkg::FW-1:0] FAULT_CODE,
  // event stream
  output logic EVT_VALID,
  output logic [1:0] EVT_CODE,
  output logic [ctsv_pkg::TW-1:0] EVT_TIME
);
  // settings
  logic residual_input_selection, counter_clear;
  logic [1:0] alarm_filter, block_filter, rec_event;
  logic [ctsv_pkg::CW-1:0] high_limit, low_limit, min_max_ratio;
  logic [ctsv_pkg::CW-1:0] sequence_ratio_threshold, mismatch_threshold;
  logic [ctsv_pkg::RW-1:0] alarm_delay;
  // condition terms
  logic [ctsv_pkg::CW-1:0] i_min, i_max;
  logic any_high, all_low, ratio_ok, seq_ok, diff_ok, pickup;
  logic [ctsv_pkg::FW-1:0] fault_now;
  // timer and state
  ctsv_pkg::ctsv_state_e state, next_state;
  logic [ctsv_pkg::RW-1:0] alarm_time_remaining;
  logic [ctsv_pkg::TICK_W-1:0] tick_cnt;
  logic tick, rec_write;
  // events
  logic alarm_d, block_d, alarm_rise, alarm_fall, block_rise, block_fall;
  logic [3:0] pend, pend_new, pend_take;
  logic [ctsv_pkg::CNT_W-1:0] event_count;
  // trigger samples and log
  logic [ctsv_pkg::CW-1:0] smp [7];
  logic [ctsv_pkg::GW-1:0] smp_group;
  logic [ctsv_pkg::LOG_AW-1:0] wptr, log_count, log_entry, rd_addr;
  logic [2:0] log_word;
  logic [4:0] rd_slot;
  logic [ctsv_pkg::LOG_WIDTH-1:0] rec_wr, rec_rd;
  logic [ctsv_pkg::DW-1:0] log_rdata;
  // phase extremes
  always_comb
  begin
    i_max = I_L1;
    i_min = I_L1;
    if (I_L2 > i_max) i_max = I_L2;
    if (I_L3 > i_max) i_max = I_L3;
    if (I_L2 < i_min) i_min = I_L2;
    if (I_L3 < i_min) i_min = I_L3;
  end
  // activation conditions; ratios by cross products, no dividers
  assign any_high = (I_L1 > high_limit) | (I_L2 > high_limit) | (I_L3 > high_limit); // [RQ2]
  assign all_low = (I_L1 < low_limit) & (I_L2 < low_limit) & (I_L3 < low_limit); // [RQ3]
  assign ratio_ok = (32'(i_min) * ctsv_pkg::RATIO_SCALE) < (32'(min_max_ratio) * 32'(i_max)); // [RQ17]
  assign seq_ok = (32'(I_NEG) * ctsv_pkg::RATIO_SCALE) > (32'(sequence_ratio_threshold) * 32'(I_POS)); // [RQ17]
  assign diff_ok = ~residual_input_selection | (I_SUM_DIFF >= mismatch_threshold); // [RQ4] [RQ5] [RQ6]
  assign pickup = ~any_high & ~all_low & ratio_ok & seq_ok & diff_ok; // [RQ7]
  assign fault_now = {diff_ok, seq_ok, ratio_ok, all_low, any_high};
  // state decisions, once per program cycle; timer expiry taken in any cycle
  always_comb
  begin
    next_state = state;
    case (state)
      ctsv_pkg::ST_IDLE:
      begin
        if (PROG_CYCLE && pickup)
        begin
          if (BLOCK_IN) next_state = ctsv_pkg::ST_BLOCKED; // [RQ18]
          else if (alarm_delay == '0) next_state = ctsv_pkg::ST_ALARM;
          else next_state = ctsv_pkg::ST_TIMING; // [RQ1]
        end
      end
      ctsv_pkg::ST_TIMING:
      begin
        if (PROG_CYCLE && !pickup) next_state = ctsv_pkg::ST_IDLE; // [RQ20]
        else if (PROG_CYCLE && BLOCK_IN) next_state = ctsv_pkg::ST_BLOCKED; // [RQ18]
        else if (alarm_time_remaining == '0) next_state = ctsv_pkg::ST_ALARM; // [RQ1]
      end
      ctsv_pkg::ST_ALARM:
      begin
        if (PROG_CYCLE && !pickup) next_state = ctsv_pkg::ST_IDLE; // [RQ20]
        else if (PROG_CYCLE && BLOCK_IN) next_state = ctsv_pkg::ST_BLOCKED; // [RQ18]
      end
      ctsv_pkg::ST_BLOCKED:
      begin
        if (PROG_CYCLE && !pickup) next_state = ctsv_pkg::ST_IDLE;
        else if (PROG_CYCLE && !BLOCK_IN)
        begin
          if (alarm_delay == '0) next_state = ctsv_pkg::ST_ALARM; // full delay after block
          else next_state = ctsv_pkg::ST_TIMING;
        end
      end
      default: next_state = ctsv_pkg::ST_IDLE;
    endcase
  end
  // state register
  always_ff @(posedge MCLK)
    state <= RST ? ctsv_pkg::ST_IDLE : next_state;
  // 5 ms steps, restarted with each timing run
  always_ff @(posedge MCLK)
    tick_cnt <= (RST || state != ctsv_pkg::ST_TIMING || tick) ? '0 : tick_cnt + 1'b1;
  assign tick = (tick_cnt == ctsv_pkg::TICK_W'(STEP_CYCLES - 1));
  // remaining time: full delay when idle, zero once alarmed
  always_ff @(posedge MCLK)
  begin
    if (RST) alarm_time_remaining <= ctsv_pkg::RST_DELAY;
    else if (next_state != ctsv_pkg::ST_TIMING)
      alarm_time_remaining <= (next_state == ctsv_pkg::ST_ALARM) ? '0 : alarm_delay; // [RQ20]
    else if (state != ctsv_pkg::ST_TIMING) alarm_time_remaining <= alarm_delay; // [RQ1]
    else if (tick && alarm_time_remaining != '0)
      alarm_time_remaining <= alarm_time_remaining - 1'b1; // [RQ19]
  end
  // direct outputs for output control and user logic
  assign START = (state == ctsv_pkg::ST_TIMING) | (state == ctsv_pkg::ST_ALARM); // [RQ12]
  assign ALARM = (state == ctsv_pkg::ST_ALARM); // [RQ12]
  assign BLOCKED = (state == ctsv_pkg::ST_BLOCKED); // [RQ12]
  // status edges become events
  always_ff @(posedge MCLK)
  begin
    alarm_d <= !RST && ALARM;
    block_d <= !RST && BLOCKED;
  end
  assign alarm_rise = ALARM & ~alarm_d; // [RQ8]
  assign alarm_fall = ~ALARM & alarm_d; // [RQ8]
  assign block_rise = BLOCKED & ~block_d; // [RQ8]
  assign block_fall = ~BLOCKED & block_d; // [RQ8]
  // filtered edges pend; lowest goes first, one per cycle
  assign pend_new = {block_fall & block_filter[ctsv_pkg::FLT_OFF_BIT],
                     block_rise & block_filter[ctsv_pkg::FLT_ON_BIT],
                     alarm_fall & alarm_filter[ctsv_pkg::FLT_OFF_BIT],
                     alarm_rise & alarm_filter[ctsv_pkg::FLT_ON_BIT]}; // [RQ9]
  assign pend_take = pend & (~pend + 4'h1);
  // pending events; a new edge wins over the slot being served
  always_ff @(posedge MCLK)
    pend <= RST ? 4'h0 : (pend & ~pend_take) | pend_new;
  // event stage; stamp taken as the event leaves, a few cycles late
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      EVT_VALID <= 1'b0;
      EVT_CODE <= 2'h0;
      EVT_TIME <= '0;
    end
    else
    begin
      EVT_VALID <= (pend_take != 4'h0);
      EVT_TIME <= TIME_MS; // [RQ10]
      case (pend_take)
        4'h2: EVT_CODE <= 2'(ctsv_pkg::EV_ALARM_OFF);
        4'h4: EVT_CODE <= 2'(ctsv_pkg::EV_BLOCK_ON);
        4'h8: EVT_CODE <= 2'(ctsv_pkg::EV_BLOCK_OFF);
        default: EVT_CODE <= 2'(ctsv_pkg::EV_ALARM_ON);
      endcase
    end
  end
  // counter; a count in the clear cycle survives as one
  always_ff @(posedge MCLK)
  begin
    if (RST) event_count <= '0;
    else if (counter_clear) event_count <= ctsv_pkg::CNT_W'(alarm_rise | block_rise); // [RQ11]
    else if (alarm_rise || block_rise) event_count <= event_count + 1'b1; // [RQ11]
  end
  // trigger samples taken every program cycle
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      for (int k = 0; k < 7; k++) smp[k] <= '0;
      smp_group <= '0;
      FAULT_CODE <= '0;
    end
    else if (PROG_CYCLE)
    begin
      smp[0] <= I_L1; // [RQ15]
      smp[1] <= I_L2;
      smp[2] <= I_L3;
      smp[3] <= I_RES1;
      smp[4] <= I_RES2;
      smp[5] <= I_POS;
      smp[6] <= I_NEG;
      smp_group <= SET_GROUP; // [RQ14]
      FAULT_CODE <= fault_now; // [RQ14]
    end
  end
  // a record on every on event, filter or not
  assign rec_write = alarm_rise | block_rise; // [RQ13]
  assign rec_event = alarm_rise ? 2'(ctsv_pkg::EV_ALARM_ON) : 2'(ctsv_pkg::EV_BLOCK_ON);
  assign rec_wr = {13'h0000, alarm_time_remaining, // [RQ16]
                   16'h0000, smp[6], smp[5], smp[4], smp[3], smp[2], smp[1], smp[0],
                   FAULT_CODE, smp_group, rec_event, 6'h00, TIME_MS}; // [RQ14] [RQ15]
  // pointer wraps, oldest record overwritten
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      wptr <= '0;
      log_count <= '0;
    end
    else if (rec_write)
    begin
      wptr <= (wptr == ctsv_pkg::LOG_AW'(ctsv_pkg::LOG_DEPTH - 1)) ? '0 : wptr + 1'b1; // [RQ13]
      if (log_count != ctsv_pkg::LOG_AW'(ctsv_pkg::LOG_DEPTH)) log_count <= log_count + 1'b1;
    end
  end
  // entry 0 is the newest record
  always_comb
  begin
    rd_slot = 5'(wptr) + 5'(ctsv_pkg::LOG_DEPTH - 1) - 5'(log_entry);
    if (rd_slot >= 5'(ctsv_pkg::LOG_DEPTH)) rd_slot = rd_slot - 5'(ctsv_pkg::LOG_DEPTH);
    rd_addr = rd_slot[ctsv_pkg::LOG_AW-1:0];
  end
  // record store
  ctsv_log_mem i_ctsv_log_mem (.clk(MCLK), .wr_en(rec_write), .wr_addr(wptr),
    .wr_data(rec_wr), .rd_addr(rd_addr), .rd_data(rec_rd));
  // unwritten entries and words past the record read as zero
  assign log_rdata = (log_entry >= log_count || log_word >= 3'(ctsv_pkg::LOG_WORDS)) ? '0 :
                     rec_rd[32'(log_word) * ctsv_pkg::DW +: ctsv_pkg::DW];
  // settings writes
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      residual_input_selection <= 1'b0;
      alarm_filter <= ctsv_pkg::RST_FILTER;
      block_filter <= ctsv_pkg::RST_FILTER;
      high_limit <= ctsv_pkg::RST_HIGH;
      low_limit <= ctsv_pkg::RST_LOW;
      min_max_ratio <= ctsv_pkg::RST_RATIO;
      sequence_ratio_threshold <= ctsv_pkg::RST_SEQ;
      mismatch_threshold <= ctsv_pkg::RST_SUMDIFF;
      alarm_delay <= ctsv_pkg::RST_DELAY;
      log_entry <= '0;
      log_word <= '0;
    end
    else if (WR)
    begin
      case (ADDR)
        ctsv_pkg::ADDR_CTRL:
        begin
          residual_input_selection <= WDATA[ctsv_pkg::CTRL_RES_BIT];
          alarm_filter <= WDATA[ctsv_pkg::CTRL_AFLT_LSB +: 2];
          block_filter <= WDATA[ctsv_pkg::CTRL_BFLT_LSB +: 2];
        end
        ctsv_pkg::ADDR_LIMIT:
        begin
          high_limit <= WDATA[15:0];
          low_limit <= WDATA[31:16];
        end
        ctsv_pkg::ADDR_RATIO:
        begin
          min_max_ratio <= WDATA[15:0];
          sequence_ratio_threshold <= WDATA[31:16];
        end
        ctsv_pkg::ADDR_SUMDIFF: mismatch_threshold <= WDATA[15:0];
        // values above 1800 s saturate rather than wrap
        ctsv_pkg::ADDR_DELAY: alarm_delay <= (WDATA[ctsv_pkg::RW-1:0] > ctsv_pkg::MAX_DELAY) ?
                                             ctsv_pkg::MAX_DELAY : WDATA[ctsv_pkg::RW-1:0]; // [RQ19]
        ctsv_pkg::ADDR_LOGSEL:
        begin
          log_entry <= WDATA[ctsv_pkg::LSEL_ENTRY_LSB +: ctsv_pkg::LOG_AW];
          log_word <= WDATA[ctsv_pkg::LSEL_WORD_LSB +: 3];
        end
        default: ;
      endcase
    end
  end
  assign counter_clear = WR & (ADDR == ctsv_pkg::ADDR_CTRL) & WDATA[ctsv_pkg::CTRL_CLR_BIT];
  // read data stand for one cycle only, zero otherwise
  always_ff @(posedge MCLK)
  begin
    if (RST || !RD) RDATA <= '0;
    else
    begin
      case (ADDR)
        ctsv_pkg::ADDR_CTRL: RDATA <= 32'({block_filter, alarm_filter, residual_input_selection});
        ctsv_pkg::ADDR_LIMIT: RDATA <= {low_limit, high_limit};
        ctsv_pkg::ADDR_RATIO: RDATA <= {sequence_ratio_threshold, min_max_ratio};
        ctsv_pkg::ADDR_SUMDIFF: RDATA <= 32'(mismatch_threshold);
        ctsv_pkg::ADDR_DELAY: RDATA <= 32'(alarm_delay);
        ctsv_pkg::ADDR_STATUS: RDATA <= 32'({FAULT_CODE, BLOCKED, ALARM, START});
        ctsv_pkg::ADDR_REMAIN: RDATA <= 32'(alarm_time_remaining);
        ctsv_pkg::ADDR_COUNT: RDATA <= 32'(event_count);
        ctsv_pkg::ADDR_LOGSEL: RDATA <= {12'h000, log_count, 5'h00, log_word, 4'h0, log_entry};
        ctsv_pkg::ADDR_LOGDATA: RDATA <= log_rdata;
        default: RDATA <= '0;
      endcase
    end
  end
endmodule

// File: dv/ctsv_checker.sv
// assertions on the ports of the supervision block, attached by bind
// assumes settings change only through the register port
`timescale 1ns/1ps
module ctsv_checker #(
  parameter int STEP_CYCLES = ctsv_pkg::STEP_CYCLES
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // register port
  input wire logic [ctsv_pkg::AW-1:0] ADDR,
  input wire logic [ctsv_pkg::DW-1:0] WDATA,
  input wire logic WR,
  // program cycle context
  input wire logic PROG_CYCLE,
  input wire logic BLOCK_IN,
  input wire logic [ctsv_pkg::TW-1:0] TIME_MS,
  input wire logic [ctsv_pkg::CW-1:0] I_SUM_DIFF,
  // supervision outputs and events
  input wire logic START,
  input wire logic ALARM,
  input wire logic BLOCKED,
  input wire logic [ctsv_pkg::FW-1:0] FAULT_CODE,
  input wire logic EVT_VALID,
  input wire logic [1:0] EVT_CODE,
  input wire logic [ctsv_pkg::TW-1:0] EVT_TIME
);
  localparam logic [4:0] PICK = 5'h1c;
  logic [ctsv_pkg::RW-1:0] dly;
  logic [ctsv_pkg::CW-1:0] sd_thr;
  logic [4:0] ctl;
  logic [39:0] run;
  longint lo;
  longint hi;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // settings shadow, fed by software writes
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      dly <= ctsv_pkg::RST_DELAY;
      sd_thr <= ctsv_pkg::RST_SUMDIFF;
      ctl <= 5'h1e;
    end
    else if (WR)
    begin
      if (ADDR == ctsv_pkg::ADDR_DELAY)
        dly <= (WDATA[18:0] > ctsv_pkg::MAX_DELAY) ? ctsv_pkg::MAX_DELAY : WDATA[18:0];
      if (ADDR == ctsv_pkg::ADDR_SUMDIFF)
        sd_thr <= WDATA[15:0];
      if (ADDR == ctsv_pkg::ADDR_CTRL)
        ctl <= WDATA[4:0];
    end
  end
  // timing run length; the tick restarts with each run, yet the window allows one step of slack
  always_ff @(posedge MCLK)
    run <= (START && !ALARM && !RST) ? run + 40'h1 : 40'h0;
  always_comb
  begin
    lo = (longint'(dly) - 1) * STEP_CYCLES + 1;
    hi = longint'(dly) * STEP_CYCLES + 2;
  end
  property p_alarm_delay;
    $rose(ALARM) && dly != 0 |-> longint'(run) >= lo && longint'(run) <= hi;
  endproperty
  a_alarm_delay: assert property (p_alarm_delay) else $error("alarm off its delay");
  property p_start_high;
    $rose(START) |-> !FAULT_CODE[ctsv_pkg::FC_HIGH];
  endproperty
  a_start_high: assert property (p_start_high) else $error("start above upper limit");
  property p_start_low;
    $rose(START) |-> !FAULT_CODE[ctsv_pkg::FC_ALLLOW];
  endproperty
  a_start_low: assert property (p_start_low) else $error("start with all phases low");
  property p_start_ratio;
    $rose(START) |-> FAULT_CODE[ctsv_pkg::FC_RATIO] && FAULT_CODE[ctsv_pkg::FC_SEQ];
  endproperty
  a_start_ratio: assert property (p_start_ratio) else $error("start without ratios");
  property p_diff_code;
    $past(PROG_CYCLE) |-> FAULT_CODE[ctsv_pkg::FC_DIFF] ==
      (!$past(ctl[0]) || $past(I_SUM_DIFF) >= $past(sd_thr));
  endproperty
  a_diff_code: assert property (p_diff_code) else $error("residual check wrong");
  property p_block;
    $past(PROG_CYCLE && BLOCK_IN) && FAULT_CODE == PICK |-> BLOCKED && !START;
  endproperty
  a_block: assert property (p_block) else $error("block not taken");
  property p_lost;
    $past(PROG_CYCLE) && FAULT_CODE != PICK |-> !START && !BLOCKED;
  endproperty
  a_lost: assert property (p_lost) else $error("state kept without pickup");
  property p_alarm_evt;
    $rose(ALARM) && ctl[1] |-> ##[2:5] EVT_VALID && EVT_CODE == ctsv_pkg::EV_ALARM_ON;
  endproperty
  a_alarm_evt: assert property (p_alarm_evt) else $error("alarm on event missing");
  property p_filter;
    EVT_VALID |-> ctl[{1'b0, EVT_CODE} + 3'h1];
  endproperty
  a_filter: assert property (p_filter) else $error("filtered event emitted");
  property p_evt_time;
    EVT_VALID |-> EVT_TIME == $past(TIME_MS);
  endproperty
  a_evt_time: assert property (p_evt_time) else $error("event stamp wrong");
  c_alarm: cover property ($rose(ALARM));
  c_block: cover property ($rose(BLOCKED));
  c_block_off: cover property (EVT_VALID && EVT_CODE == ctsv_pkg::EV_BLOCK_OFF);
endmodule

// File: dv/ctsv_partner.sv
// partner model: program cycle source and time base of the relay
// assumes the bench drives measurements; events are only counted here
`timescale 1ns/1ps
module ctsv_partner (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // program cycle context
  output logic prog_cycle,
  output logic [ctsv_pkg::TW-1:0] time_ms,
  // event stream
  input wire logic evt_valid,
  output int evt_seen
);
  logic [2:0] phase;
  // quiet at time zero: no unknown strobe
  initial
  begin
    prog_cycle = 1'b0;
    time_ms = '0;
    phase = 3'h0;
    evt_seen = 0;
  end
  // a program cycle every eight clocks, well under the delays used
  always @(posedge clk)
  begin
    phase <= rst ? 3'h0 : phase + 3'h1;
    prog_cycle <= !rst && phase == 3'h7;
    time_ms <= rst ? '0 : time_ms + 48'h1;
    evt_seen <= rst ? 0 : evt_seen + int'(evt_valid);
  end
endmodule

// File: dv/ctsv_top_bench.sv
// self-checking bench of the supervision block with its partner model
// assumes STEP_CYCLES of 4 for short delays
`timescale 1ns/1ps
module ctsv_top_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic block_in = 1'b0;
  logic [2:0] set_group = 3'h0;
  logic [15:0] i_l1, i_l2, i_l3, i_res1, i_res2, i_pos, i_neg, i_sum_diff;
  logic [31:0] rdata;
  logic alarm, evt_valid, prog, rd_seen;
  logic [1:0] evt_code;
  logic [47:0] time_ms, evt_time, t_prev;
  logic [31:0] exp_rd [$];
  logic [1:0] exp_ev [$];
  int num_errors = 0;
  int compares = 0;
  int evt_seen;
  always #12.5 mclk = ~mclk;
  ctsv_top #(.STEP_CYCLES(4)) i_ctsv_top (.MCLK(mclk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .PROG_CYCLE(prog),
    .BLOCK_IN(block_in), .TIME_MS(time_ms), .SET_GROUP(set_group), .I_L1(i_l1),
    .I_L2(i_l2), .I_L3(i_l3), .I_RES1(i_res1), .I_RES2(i_res2), .I_POS(i_pos),
    .I_NEG(i_neg), .I_SUM_DIFF(i_sum_diff), .START(), .ALARM(alarm), .BLOCKED(),
    .FAULT_CODE(), .EVT_VALID(evt_valid), .EVT_CODE(evt_code), .EVT_TIME(evt_time));
  ctsv_partner i_ctsv_partner (.clk(mclk), .rst(rst), .prog_cycle(prog),
    .time_ms(time_ms), .evt_valid(evt_valid), .evt_seen(evt_seen));
  task automatic conclude();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
  endtask
  // noted here, judged by the monitor a cycle later
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
  endtask
  task automatic meas(input logic [15:0] a, b, c, p, n);
    i_l1 <= a;
    i_l2 <= b;
    i_l3 <= c;
    i_pos <= p;
    i_neg <= n;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // monitor: read data stand only in the cycle after the strobe
  always @(posedge mclk)
  begin
    if (rd_seen === 1'b1)
      check("rdata", rdata, exp_rd.pop_front());
    rd_seen <= rd_s && !rst;
    if (evt_valid === 1'b1)
    begin
      if (exp_ev.size() == 0)
        check("evt_extra", 1'b1, 1'b0);
      else
        check("evt_code", evt_code, exp_ev.pop_front());
      check("evt_time", evt_time, t_prev);
    end
    t_prev <= time_ms;
  end
  // watchdog, far beyond the few hundred cycles needed
  initial
  begin
    #500000;
    num_errors++;
    conclude();
  end
  initial
  begin
    int g;
    int l1;
    void'($urandom(32'h043a));
    i_res1 = 16'($urandom_range(50));
    i_res2 = 16'($urandom_range(50));
    i_sum_diff = 16'h0;
    rd_seen = 1'b0;
    meas(16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
    wait_cyc(3);
    rst <= 1'b0;
    rd_chk(ctsv_pkg::ADDR_LIMIT, 32'h000a0078);
    rd_chk(ctsv_pkg::ADDR_RATIO, 32'h132403e8);
    rd_chk(ctsv_pkg::ADDR_SUMDIFF, 32'ha);
    rd_chk(ctsv_pkg::ADDR_CTRL, 32'h1e);
    rd_chk(ctsv_pkg::ADDR_COUNT, 32'h0);
    rd_chk(8'h40, 32'h0);
    rd_chk(ctsv_pkg::ADDR_DELAY, 32'h64);
    wr(ctsv_pkg::ADDR_DELAY, 32'h7ffff);
    rd_chk(ctsv_pkg::ADDR_DELAY, 32'(ctsv_pkg::MAX_DELAY));
    wr(ctsv_pkg::ADDR_DELAY, 32'h3);
    // lost phase alarms without residual check
    exp_ev.push_back(ctsv_pkg::EV_ALARM_ON);
    meas(16'h0, 16'h64, 16'h64, 16'h43, 16'h21);
    for (int n = 0; n < 200 && alarm !== 1'b1; n++)
      @(posedge mclk);
    rd_chk(ctsv_pkg::ADDR_STATUS, 32'he3);
    exp_ev.push_back(ctsv_pkg::EV_ALARM_OFF);
    meas(16'h64, 16'h64, 16'h64, 16'h64, 16'h0);
    wait_cyc(20);
    rd_chk(ctsv_pkg::ADDR_STATUS, 32'h80);
    rd_chk(ctsv_pkg::ADDR_COUNT, 32'h1);
    meas(16'h0, 16'h96, 16'h64, 16'h43, 16'h21);
    wait_cyc(20);
    rd_chk(ctsv_pkg::ADDR_STATUS, 32'he8);
    meas(16'h0, 16'h5, 16'h5, 16'h3, 16'h2);
    wait_cyc(20);
    rd_chk(ctsv_pkg::ADDR_STATUS, 32'hf0);
    // residual check on: small differences withhold activation
    wr(ctsv_pkg::ADDR_DELAY, 32'h32);
    wr(ctsv_pkg::ADDR_CTRL, 32'h1f);
    meas(16'h0, 16'h64, 16'h64, 16'h43, 16'h21);
    for (int k = 0; k < 3; k++)
    begin
      i_sum_diff <= (k == 2) ? 16'ha : 16'(9 * k);
      wait_cyc(20);
      rd_chk(ctsv_pkg::ADDR_STATUS, (k == 2) ? 32'he1 : 32'h60);
    end
    // thirteen block cycles overrun the twelve-deep log
    for (int k = 0; k < 13; k++)
    begin
      g = $urandom_range(7);
      l1 = $urandom_range(9);
      set_group <= g[2:0];
      i_l1 <= l1[15:0];
      block_in <= 1'b1;
      exp_ev.push_back(ctsv_pkg::EV_BLOCK_ON);
      wait_cyc(10);
      if (k == 0)
        rd_chk(ctsv_pkg::ADDR_STATUS, 32'he4);
      if (k == 0)
        rd_chk(ctsv_pkg::ADDR_REMAIN, 32'h32);
      block_in <= 1'b0;
      exp_ev.push_back(ctsv_pkg::EV_BLOCK_OFF);
      wait_cyc(10);
    end
    wr(ctsv_pkg::ADDR_LOGSEL, 32'h100);
    rd_chk(ctsv_pkg::ADDR_LOGSEL, 32'h000c0100);
    rd_chk(ctsv_pkg::ADDR_LOGDATA, {5'h1c, g[2:0], 2'h2, 22'h0});
    wr(ctsv_pkg::ADDR_LOGSEL, 32'h200);
    rd_chk(ctsv_pkg::ADDR_LOGDATA, {16'h0064, l1[15:0]});
    wr(ctsv_pkg::ADDR_LOGSEL, 32'h300);
    rd_chk(ctsv_pkg::ADDR_LOGDATA, {i_res1, 16'h0064});
    wr(ctsv_pkg::ADDR_LOGSEL, 32'hc);
    rd_chk(ctsv_pkg::ADDR_LOGDATA, 32'h0);
    // block filter off only: no block on event
    wr(ctsv_pkg::ADDR_CTRL, 32'h17);
    rd_chk(ctsv_pkg::ADDR_CTRL, 32'h17);
    block_in <= 1'b1;
    wait_cyc(10);
    block_in <= 1'b0;
    exp_ev.push_back(ctsv_pkg::EV_BLOCK_OFF);
    wait_cyc(10);
    rd_chk(ctsv_pkg::ADDR_COUNT, 32'hf);
    wr(ctsv_pkg::ADDR_CTRL, 32'h117);
    rd_chk(ctsv_pkg::ADDR_COUNT, 32'h0);
    wait_cyc(20);
    check("events_left", 48'(exp_ev.size()), 48'h0);
    check("partner_events", 48'(evt_seen), 48'h1d);
    conclude();
  end
endmodule
bind ctsv_top ctsv_checker #(.STEP_CYCLES(STEP_CYCLES)) i_ctsv_checker (.MCLK(MCLK),
  .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .PROG_CYCLE(PROG_CYCLE),
  .BLOCK_IN(BLOCK_IN), .TIME_MS(TIME_MS), .I_SUM_DIFF(I_SUM_DIFF), .START(START),
  .ALARM(ALARM), .BLOCKED(BLOCKED), .FAULT_CODE(FAULT_CODE), .EVT_VALID(EVT_VALID),
  .EVT_CODE(EVT_CODE), .EVT_TIME(EVT_TIME));
